// file: common/apd_pkg.sv
// Shared constants and types for the ATA host port decode block
package apd_pkg;
  // Clock and first power-up busy period
  localparam int unsigned MCLK_HZ     = 25_000_000;
  localparam int unsigned INIT_TIME_S = 7;
  localparam int unsigned INIT_CYCLES = INIT_TIME_S * MCLK_HZ;
  localparam int unsigned CNT_W       = 28;
  // Host register select values
  localparam logic [2:0] TF_DATA     = 3'h0;
  localparam logic [2:0] TF_FEATURE  = 3'h1;
  localparam logic [2:0] TF_COMMAND  = 3'h7;
  localparam logic [2:0] ALT_CTRL    = 3'h6;
  localparam int unsigned TF_LBA_LO  = 3;
  // Command codes
  localparam logic [7:0] CMD_PIN_FUNC = 8'h8B;
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0] FEAT_8BIT_ON = 8'h01;
  localparam logic [7:0] FEAT_8BIT_OFF = 8'h81;
  // Status and error values
  localparam logic [7:0] ST_READY   = 8'h50;
  localparam logic [7:0] ST_BUSY    = 8'h80;
  localparam logic [7:0] ST_REJECT  = 8'h51;
  localparam logic [7:0] ERR_REJECT = 8'h04;
  localparam logic [7:0] ERR_NONE   = 8'h00;
  localparam int unsigned ST_DRQ_BIT = 3;
  localparam int unsigned SRST_BIT   = 2;
  // Default geometry
  localparam logic [15:0] GEO_CYL    = 16'd14173;
  localparam logic [7:0]  GEO_HEADS  = 8'd16;
  localparam logic [7:0]  GEO_SECT   = 8'd63;
  localparam logic [31:0] GEO_MAXLBA = 32'd14286384;
  // Register bus offsets
  localparam logic [7:0] RB_CTRL    = 8'h00;
  localparam logic [7:0] RB_CMD     = 8'h04;
  localparam logic [7:0] RB_TFSTAT  = 8'h08;
  localparam logic [7:0] RB_DATA    = 8'h0C;
  localparam logic [7:0] RB_GEOM    = 8'h10;
  localparam logic [7:0] RB_MAXLBA  = 8'h14;
  localparam logic [7:0] RB_ZCFG    = 8'h18;
  localparam logic [7:0] RB_UNLOCK  = 8'h1C;
  localparam logic [7:0] RB_ZONE    = 8'h20;
  localparam logic [7:0] RB_KEY     = 8'h40;
  localparam int unsigned ZONES     = 4;
  localparam int unsigned SYNC_W    = 26;

  typedef enum logic [2:0] {
    ACC_NONE, ACC_TF, ACC_DATA, ACC_CTRL, ACC_INVALID
  } apd_acc_t;

  typedef enum logic [2:0] {
    S_LOAD, S_INIT, S_IDLE, S_BUSY, S_PDOWN
  } apd_state_t;
endpackage : apd_pkg

// file: rtl/apd_port.sv
// Device-side ATA host port: decode, pin modes, zones and diagnostic link
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module apd_port #(
  parameter int unsigned INIT_CYCLES = apd_pkg::INIT_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        primary_block_select_n,
  input  wire logic        alternate_block_select_n,
  input  wire logic        io_read_strobe_n,
  input  wire logic        io_write_strobe_n,
  input  wire logic [2:0]  register_select_bits,
  input  wire logic [7:0]  upper_data_byte_in,
  input  wire logic [7:0]  lower_data_byte_in,
  output logic      [7:0]  upper_data_byte_out,
  output logic      [7:0]  lower_data_byte_out,
  output logic             upper_data_byte_oe_n,
  output logic             lower_data_byte_oe_n,
  input  wire logic        protect_powerdown_pin_n,
  input  wire logic        diag_serial_clock,
  input  wire logic        diag_serial_in,
  output logic             diag_serial_out,
  input  wire logic        nv_pd_mode,
  input  wire logic        nv_init_done,
  output logic             nv_wr,
  output logic             nv_pd_mode_out,
  output logic             nv_init_done_out,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);

  // Decode of the host selects and register address
  function automatic apd_pkg::apd_acc_t decode(
    input logic       cs1_n,
    input logic       cs3_n,
    input logic [2:0] a
  );
    if (cs1_n && cs3_n) begin
      decode = apd_pkg::ACC_NONE;
    end else if (!cs1_n && !cs3_n) begin
      decode = apd_pkg::ACC_INVALID;
    end else if (!cs1_n) begin
      decode = (a == apd_pkg::TF_DATA) ? apd_pkg::ACC_DATA
                                       : apd_pkg::ACC_TF;
    end else begin
      decode = (a == apd_pkg::ALT_CTRL) ? apd_pkg::ACC_CTRL
                                        : apd_pkg::ACC_NONE;
    end
  endfunction : decode

  function automatic logic is_destructive(input logic [7:0] c);
    unique case (c)
      8'hCA, 8'hCB, 8'h35, 8'hC5, 8'h39, 8'h30, 8'h31,
      8'h3C, 8'hC0, 8'h50: is_destructive = 1'b1;
      default:             is_destructive = 1'b0;
    endcase
  endfunction : is_destructive

  function automatic logic is_read_cmd(input logic [7:0] c);
    unique case (c)
      8'h20, 8'h21, 8'h24, 8'h25, 8'h29, 8'hC4, 8'hC8,
      8'hC9, 8'h40, 8'h41, 8'h42: is_read_cmd = 1'b1;
      default:                   is_read_cmd = 1'b0;
    endcase
  endfunction : is_read_cmd

  // Two-flop synchroniser for every pin input
  logic [apd_pkg::SYNC_W-1:0] pin_raw;
  logic [apd_pkg::SYNC_W-1:0] sync1_r;
  logic [apd_pkg::SYNC_W-1:0] sync2_r;
  logic [apd_pkg::SYNC_W-1:0] sync1_nxt;
  logic [apd_pkg::SYNC_W-1:0] sync2_nxt;

  assign pin_raw = {primary_block_select_n, alternate_block_select_n,
                    io_read_strobe_n, io_write_strobe_n,
                    register_select_bits, protect_powerdown_pin_n,
                    diag_serial_clock, diag_serial_in,
                    upper_data_byte_in, lower_data_byte_in};

  always_comb begin
    sync1_nxt = ce ? pin_raw : sync1_r;
    sync2_nxt = ce ? sync1_r : sync2_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= {apd_pkg::SYNC_W{1'b1}};
      sync2_r <= {apd_pkg::SYNC_W{1'b1}};
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  logic        s_cs1_n, s_cs3_n, s_rd_n, s_wr_n, s_pin_n, s_dclk, s_din;
  logic [2:0]  s_addr;
  logic [15:0] s_data;
  assign {s_cs1_n, s_cs3_n, s_rd_n, s_wr_n, s_addr, s_pin_n,
          s_dclk, s_din, s_data} = sync2_r;

  apd_pkg::apd_acc_t acc;
  assign acc = decode(s_cs1_n, s_cs3_n, s_addr);

  // Main state
  apd_pkg::apd_state_t state_r, state_nxt;
  logic [7:0]  tf_r [1:6];
  logic [7:0]  tf_nxt [1:6];
  logic [7:0]  status_r, status_nxt, error_r, error_nxt, cmd_r, cmd_nxt;
  logic [7:0]  devctl_r, devctl_nxt;
  logic        pending_r, pending_nxt, wide8_r, wide8_nxt;
  logic        pd_mode_r, pd_mode_nxt;
  logic        wr_prev_r, wr_prev_nxt, rd_prev_r, rd_prev_nxt;
  logic [15:0] host_word_r, host_word_nxt, fw_word_r, fw_word_nxt;
  logic        host_wvalid_r, host_wvalid_nxt, host_rdone_r, host_rdone_nxt;
  logic [apd_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic        nv_wr_r, nv_wr_nxt, nv_pd_r, nv_pd_nxt;
  logic        nv_done_r, nv_done_nxt;
  logic [7:0]  zcfg_r, zcfg_nxt;
  logic [27:0] zlo_r [apd_pkg::ZONES];
  logic [27:0] zhi_r [apd_pkg::ZONES];
  logic [27:0] zlo_nxt [apd_pkg::ZONES];
  logic [27:0] zhi_nxt [apd_pkg::ZONES];
  logic [31:0] key_r, key_nxt;
  logic        unlocked_r, unlocked_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0]  dhi_r, dhi_nxt, dlo_r, dlo_nxt;
  logic        oehi_n_r, oehi_n_nxt, oelo_n_r, oelo_n_nxt;

  // Zone hits against the task-file LBA
  logic [27:0] lba;
  logic [apd_pkg::ZONES-1:0] zone_hit, zone_hidden;
  assign lba = {tf_r[6][3:0], tf_r[5], tf_r[4], tf_r[apd_pkg::TF_LBA_LO]};

  for (genvar gi = 0; gi < apd_pkg::ZONES; gi++) begin : g_zone
    // Bit 2i enables, bit 2i+1 hides the zone; password lifts both
    assign zone_hit[gi] = zcfg_r[2*gi] && !unlocked_r &&
                          lba >= zlo_r[gi] && lba <= zhi_r[gi];
    assign zone_hidden[gi] = zone_hit[gi] && zcfg_r[2*gi+1];
  end

  logic pin_asserted;
  assign pin_asserted = !s_pin_n;

  logic wr_end, rd_end;
  assign wr_end = !wr_prev_r && s_wr_n;
  assign rd_end = !rd_prev_r && s_rd_n;

  always_comb begin
    logic [7:0] c;
    c = tf_r[apd_pkg::TF_FEATURE];
    state_nxt       = state_r;
    tf_nxt          = tf_r;
    status_nxt      = status_r;
    error_nxt       = error_r;
    cmd_nxt         = cmd_r;
    devctl_nxt      = devctl_r;
    pending_nxt     = pending_r;
    wide8_nxt       = wide8_r;
    pd_mode_nxt     = pd_mode_r;
    wr_prev_nxt     = s_wr_n;
    rd_prev_nxt     = s_rd_n;
    host_word_nxt   = host_word_r;
    fw_word_nxt     = fw_word_r;
    host_wvalid_nxt = host_wvalid_r;
    host_rdone_nxt  = host_rdone_r;
    cnt_nxt         = cnt_r;
    nv_wr_nxt       = 1'b0;
    nv_pd_nxt       = nv_pd_r;
    nv_done_nxt     = nv_done_r;
    zcfg_nxt        = zcfg_r;
    zlo_nxt         = zlo_r;
    zhi_nxt         = zhi_r;
    key_nxt         = key_r;
    unlocked_nxt    = unlocked_r;
    rdata_nxt       = rdata_r;

    // Firmware side of the register port
    if (reg_wr) begin
      unique case (reg_addr)
        apd_pkg::RB_CTRL: begin
          if (reg_wdata[0] && state_r == apd_pkg::S_BUSY) begin
            pending_nxt = 1'b0;
            state_nxt   = apd_pkg::S_IDLE;
          end
          if (reg_wdata[1]) host_wvalid_nxt = 1'b0;
          if (reg_wdata[2]) host_rdone_nxt = 1'b0;
        end
        apd_pkg::RB_TFSTAT: begin
          status_nxt = reg_wdata[7:0];
          error_nxt  = reg_wdata[15:8];
        end
        apd_pkg::RB_DATA:   fw_word_nxt = reg_wdata[15:0];
        apd_pkg::RB_ZCFG:   zcfg_nxt = reg_wdata[7:0];
        apd_pkg::RB_UNLOCK: unlocked_nxt = (reg_wdata == key_r);
        apd_pkg::RB_KEY: begin
          key_nxt      = reg_wdata;
          unlocked_nxt = 1'b0;
        end
        default: begin
          for (int i = 0; i < apd_pkg::ZONES; i++) begin
            if (reg_addr == apd_pkg::RB_ZONE + 8'(8 * i))
              zlo_nxt[i] = reg_wdata[27:0];
            if (reg_addr == apd_pkg::RB_ZONE + 8'(8 * i + 4))
              zhi_nxt[i] = reg_wdata[27:0];
          end
        end
      endcase
    end

    if (reg_rd) begin
      unique case (reg_addr)
        apd_pkg::RB_CTRL: rdata_nxt = {24'h0, state_r, wide8_r,
                                       pd_mode_r, pending_r,
                                       host_wvalid_r, host_rdone_r};
        apd_pkg::RB_CMD:    rdata_nxt = {24'h0, cmd_r};
        apd_pkg::RB_TFSTAT: rdata_nxt = {16'h0, error_r, status_r};
        apd_pkg::RB_DATA:   rdata_nxt = {16'h0, host_word_r};
        apd_pkg::RB_GEOM:   rdata_nxt = {apd_pkg::GEO_CYL,
                                         apd_pkg::GEO_HEADS,
                                         apd_pkg::GEO_SECT};
        apd_pkg::RB_MAXLBA: rdata_nxt = apd_pkg::GEO_MAXLBA;
        apd_pkg::RB_ZCFG:   rdata_nxt = {24'h0, zcfg_r};
        apd_pkg::RB_UNLOCK: rdata_nxt = {31'h0, unlocked_r};
        default: begin
          rdata_nxt = 32'h0;
          for (int i = 0; i < apd_pkg::ZONES; i++) begin
            if (reg_addr == apd_pkg::RB_ZONE + 8'(8 * i))
              rdata_nxt = {4'h0, zlo_r[i]};
            if (reg_addr == apd_pkg::RB_ZONE + 8'(8 * i + 4))
              rdata_nxt = {4'h0, zhi_r[i]};
          end
        end
      endcase
    end

    // Host writes complete on the rising edge of the write strobe
    if (wr_end) begin
      unique case (acc)
        apd_pkg::ACC_TF: begin
          if (s_addr != apd_pkg::TF_COMMAND) begin
            tf_nxt[s_addr] = s_data[7:0];
          end else if (state_r == apd_pkg::S_IDLE) begin
            cmd_nxt   = s_data[7:0];
            error_nxt = apd_pkg::ERR_NONE;
            if (s_data[7:0] == apd_pkg::CMD_PIN_FUNC) begin
              pd_mode_nxt = c[0];
              nv_pd_nxt   = c[0];
              nv_wr_nxt   = 1'b1;
              status_nxt  = apd_pkg::ST_READY;
            end else if (s_data[7:0] == apd_pkg::CMD_SET_FEAT &&
                         (c == apd_pkg::FEAT_8BIT_ON ||
                          c == apd_pkg::FEAT_8BIT_OFF)) begin
              wide8_nxt  = (c == apd_pkg::FEAT_8BIT_ON);
              status_nxt = apd_pkg::ST_READY;
            end else if ((is_destructive(s_data[7:0]) &&
                          ((!pd_mode_r && pin_asserted) ||
                           (|zone_hit))) ||
                         (is_read_cmd(s_data[7:0]) && (|zone_hidden))) begin
              status_nxt = apd_pkg::ST_REJECT;
              error_nxt  = apd_pkg::ERR_REJECT;
            end else begin
              pending_nxt = 1'b1;
              status_nxt  = apd_pkg::ST_BUSY;
              state_nxt   = apd_pkg::S_BUSY;
            end
          end
        end
        apd_pkg::ACC_DATA: begin
          if (status_r[apd_pkg::ST_DRQ_BIT]) begin
            host_word_nxt = wide8_r ? {8'h00, s_data[7:0]}
                                    : s_data;
            host_wvalid_nxt = 1'b1;
          end
        end
        apd_pkg::ACC_CTRL: begin
          devctl_nxt = s_data[7:0];
          if (s_data[apd_pkg::SRST_BIT] && state_r != apd_pkg::S_INIT &&
              state_r != apd_pkg::S_LOAD &&
              !(state_r == apd_pkg::S_PDOWN && pin_asserted)) begin
            state_nxt   = apd_pkg::S_IDLE;
            pending_nxt = 1'b0;
            status_nxt  = apd_pkg::ST_READY;
            error_nxt   = apd_pkg::ERR_NONE;
          end
        end
        default: ;
      endcase
    end

    if (rd_end && acc == apd_pkg::ACC_DATA) host_rdone_nxt = 1'b1;

    // Sequencing of pin modes and the first power-up
    unique case (state_r)
      apd_pkg::S_LOAD: begin
        pd_mode_nxt = nv_pd_mode;
        nv_pd_nxt   = nv_pd_mode;
        nv_done_nxt = nv_init_done;
        cnt_nxt     = '0;
        status_nxt  = nv_init_done ? apd_pkg::ST_READY : apd_pkg::ST_BUSY;
        state_nxt   = nv_init_done ? apd_pkg::S_IDLE : apd_pkg::S_INIT;
      end
      apd_pkg::S_INIT: begin
        status_nxt = apd_pkg::ST_BUSY;
        if (cnt_r == apd_pkg::CNT_W'(INIT_CYCLES - 1)) begin
          nv_done_nxt = 1'b1;
          nv_wr_nxt   = 1'b1;
          status_nxt  = apd_pkg::ST_READY;
          state_nxt   = apd_pkg::S_IDLE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      apd_pkg::S_BUSY: begin
        if (pd_mode_r && pin_asserted) begin
          pending_nxt = 1'b0;
          state_nxt   = apd_pkg::S_PDOWN;
        end
      end
      apd_pkg::S_PDOWN: pending_nxt = 1'b0;
      default: ;
    endcase
  end

  // Host read drive: bytes released unless a valid read is in progress
  always_comb begin
    oehi_n_nxt = 1'b1;
    oelo_n_nxt = 1'b1;
    dhi_nxt    = 8'h00;
    dlo_nxt    = 8'h00;
    if (!s_rd_n) begin
      unique case (acc)
        apd_pkg::ACC_TF: begin
          oelo_n_nxt = 1'b0;
          dlo_nxt = (s_addr == apd_pkg::TF_COMMAND) ? status_r :
                    (s_addr == apd_pkg::TF_FEATURE) ? error_r :
                    tf_r[s_addr];
        end
        apd_pkg::ACC_DATA: begin
          oelo_n_nxt = 1'b0;
          oehi_n_nxt = wide8_r;
          dlo_nxt    = fw_word_r[7:0];
          dhi_nxt    = fw_word_r[15:8];
        end
        apd_pkg::ACC_CTRL: begin
          oelo_n_nxt = 1'b0;
          dlo_nxt    = status_r;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= apd_pkg::S_LOAD;
      tf_r          <= '{default: 8'h00};
      status_r      <= apd_pkg::ST_BUSY;
      error_r       <= apd_pkg::ERR_NONE;
      cmd_r         <= 8'h00;
      devctl_r      <= 8'h00;
      pending_r     <= 1'b0;
      wide8_r       <= 1'b0;
      pd_mode_r     <= 1'b0;
      wr_prev_r     <= 1'b1;
      rd_prev_r     <= 1'b1;
      host_word_r   <= 16'h0000;
      fw_word_r     <= 16'h0000;
      host_wvalid_r <= 1'b0;
      host_rdone_r  <= 1'b0;
      cnt_r         <= '0;
      nv_wr_r       <= 1'b0;
      nv_pd_r       <= 1'b0;
      nv_done_r     <= 1'b0;
      zcfg_r        <= 8'h00;
      zlo_r         <= '{default: 28'h0};
      zhi_r         <= '{default: 28'h0};
      key_r         <= 32'h0000_0000;
      unlocked_r    <= 1'b0;
      rdata_r       <= 32'h0000_0000;
      dhi_r         <= 8'h00;
      dlo_r         <= 8'h00;
      oehi_n_r      <= 1'b1;
      oelo_n_r      <= 1'b1;
    end else if (ce) begin
      state_r       <= state_nxt;
      tf_r          <= tf_nxt;
      status_r      <= status_nxt;
      error_r       <= error_nxt;
      cmd_r         <= cmd_nxt;
      devctl_r      <= devctl_nxt;
      pending_r     <= pending_nxt;
      wide8_r       <= wide8_nxt;
      pd_mode_r     <= pd_mode_nxt;
      wr_prev_r     <= wr_prev_nxt;
      rd_prev_r     <= rd_prev_nxt;
      host_word_r   <= host_word_nxt;
      fw_word_r     <= fw_word_nxt;
      host_wvalid_r <= host_wvalid_nxt;
      host_rdone_r  <= host_rdone_nxt;
      cnt_r         <= cnt_nxt;
      nv_wr_r       <= nv_wr_nxt;
      nv_pd_r       <= nv_pd_nxt;
      nv_done_r     <= nv_done_nxt;
      zcfg_r        <= zcfg_nxt;
      zlo_r         <= zlo_nxt;
      zhi_r         <= zhi_nxt;
      key_r         <= key_nxt;
      unlocked_r    <= unlocked_nxt;
      rdata_r       <= rdata_nxt;
      dhi_r         <= dhi_nxt;
      dlo_r         <= dlo_nxt;
      oehi_n_r      <= oehi_n_nxt;
      oelo_n_r      <= oelo_n_nxt;
    end
  end

  // Diagnostic serial link: last two bits of the byte in select the byte shifted out
  logic       dclk_prev_r, dclk_prev_nxt;
  logic [2:0] dbit_r, dbit_nxt;
  logic [7:0] din_sh_r, din_sh_nxt, dout_sh_r, dout_sh_nxt;
  logic [1:0] dsel_r, dsel_nxt;

  always_comb begin
    dclk_prev_nxt = s_dclk;
    dbit_nxt      = dbit_r;
    din_sh_nxt    = din_sh_r;
    dout_sh_nxt   = dout_sh_r;
    dsel_nxt      = dsel_r;
    if (s_dclk && !dclk_prev_r) begin
      din_sh_nxt = {din_sh_r[6:0], s_din};
      dbit_nxt   = dbit_r + 1'b1;
      if (dbit_r == 3'h7) begin
        dsel_nxt = din_sh_r[0] ? {1'b1, s_din} : {1'b0, s_din};
        unique case (dsel_nxt)
          2'h0: dout_sh_nxt = status_r;
          2'h1: dout_sh_nxt = error_r;
          2'h2: dout_sh_nxt = cmd_r;
          2'h3: dout_sh_nxt = {1'b0, state_r, nv_done_r, pd_mode_r,
                               wide8_r, pending_r};
        endcase
      end else begin
        dout_sh_nxt = {dout_sh_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dclk_prev_r <= 1'b1;
      dbit_r      <= 3'h0;
      din_sh_r    <= 8'h00;
      dout_sh_r   <= 8'h00;
      dsel_r      <= 2'h0;
    end else if (ce) begin
      dclk_prev_r <= dclk_prev_nxt;
      dbit_r      <= dbit_nxt;
      din_sh_r    <= din_sh_nxt;
      dout_sh_r   <= dout_sh_nxt;
      dsel_r      <= dsel_nxt;
    end
  end

  assign upper_data_byte_out  = dhi_r;
  assign lower_data_byte_out  = dlo_r;
  assign upper_data_byte_oe_n = oehi_n_r;
  assign lower_data_byte_oe_n = oelo_n_r;
  assign diag_serial_out      = dout_sh_r[7];
  assign nv_wr                = nv_wr_r;
  assign nv_pd_mode_out       = nv_pd_r;
  assign nv_init_done_out     = nv_done_r;
  assign reg_rdata            = rdata_r;
endmodule : apd_port

// file: verif/apd_port_assertions.sv
// Pin checker
`timescale 1ns/1ps
module apd_port_chk (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       primary_block_select_n,
  input wire logic       alternate_block_select_n,
  input wire logic       io_read_strobe_n,
  input wire logic       io_write_strobe_n,
  input wire logic [2:0] register_select_bits,
  input wire logic       upper_data_byte_oe_n,
  input wire logic       lower_data_byte_oe_n,
  input wire logic       nv_wr,
  input wire logic       nv_init_done_out
);
  logic off;
  assign off = upper_data_byte_oe_n && lower_data_byte_oe_n;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_idle;
    primary_block_select_n && alternate_block_select_n;
  endsequence
  sequence s_tf;
    !primary_block_select_n && alternate_block_select_n &&
    register_select_bits != 3'h0;
  endsequence
  sequence s_alt;
    primary_block_select_n && !alternate_block_select_n &&
    register_select_bits == 3'h6;
  endsequence
  sequence s_rd;
    !io_read_strobe_n &&
    (primary_block_select_n != alternate_block_select_n);
  endsequence
  property p_standby; s_idle[*5] |-> off; endproperty
  property p_tf_hi; s_tf[*5] |-> upper_data_byte_oe_n; endproperty
  property p_alt_hi; s_alt[*5] |-> upper_data_byte_oe_n; endproperty
  property p_rd_drive;
    $fell(io_read_strobe_n) ##0 s_rd[*5] |-> !lower_data_byte_oe_n;
  endproperty
  property p_rd_rel; $rose(io_read_strobe_n) |-> ##[1:4] off; endproperty
  property p_wr_float; $fell(io_write_strobe_n) |-> off[*6]; endproperty
  property p_nv_pulse; nv_wr |=> !nv_wr; endproperty
  property p_nv_init; nv_wr |-> nv_init_done_out; endproperty
  a_standby: assert property (p_standby)
    else $error("idle drive");
  a_tf_hi: assert property (p_tf_hi)
    else $error("tf upper");
  a_alt_hi: assert property (p_alt_hi)
    else $error("alt upper");
  a_rd_drive: assert property (p_rd_drive)
    else $error("no read drive");
  a_rd_rel: assert property (p_rd_rel)
    else $error("no release");
  a_wr_float: assert property (p_wr_float)
    else $error("write drive");
  a_nv_pulse: assert property (p_nv_pulse)
    else $error("long store");
  a_nv_init: assert property (p_nv_init)
    else $error("early store");
endmodule : apd_port_chk
bind apd_port apd_port_chk u_chk (.mclk, .rst_n, .primary_block_select_n,
  .alternate_block_select_n, .io_read_strobe_n, .io_write_strobe_n,
  .register_select_bits, .upper_data_byte_oe_n, .lower_data_byte_oe_n,
  .nv_wr, .nv_init_done_out);

// file: verif/apd_host.sv
// Host model
`timescale 1ns/1ps
module apd_host (
  input  wire logic       mclk,
  output logic            primary_block_select_n,
  output logic            alternate_block_select_n,
  output logic            io_read_strobe_n,
  output logic            io_write_strobe_n,
  output logic [2:0]      register_select_bits,
  output logic [7:0]      upper_data_byte_in,
  output logic [7:0]      lower_data_byte_in,
  input  wire logic [7:0] upper_data_byte_out,
  input  wire logic [7:0] lower_data_byte_out,
  input  wire logic       upper_data_byte_oe_n,
  input  wire logic       lower_data_byte_oe_n
);
  logic        drv = 1'b0;
  logic [15:0] hv = 16'h0000;
  logic [15:0] last = 16'h0000;
  initial begin
    {primary_block_select_n, alternate_block_select_n, io_read_strobe_n,
     io_write_strobe_n, register_select_bits} = 7'h78;
  end
  // Released lanes show inverted data
  always_comb begin
    upper_data_byte_in = !upper_data_byte_oe_n ? upper_data_byte_out :
                         drv ? hv[15:8] : ~last[15:8];
    lower_data_byte_in = !lower_data_byte_oe_n ? lower_data_byte_out :
                         drv ? hv[7:0] : ~last[7:0];
  end
  always @(posedge mclk) last <= {upper_data_byte_in, lower_data_byte_in};
  task automatic acc(input logic alt, input logic wr, input logic [2:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge mclk);
    primary_block_select_n <= alt;
    alternate_block_select_n <= !alt;
    register_select_bits <= a;
    hv <= d;
    drv <= wr;
    repeat (3) @(posedge mclk);
    if (wr)
      io_write_strobe_n <= 1'b0;
    else
      io_read_strobe_n <= 1'b0;
    repeat (6) @(posedge mclk);
    q = {upper_data_byte_in, lower_data_byte_in};
    io_write_strobe_n <= 1'b1;
    io_read_strobe_n <= 1'b1;
    repeat (3) @(posedge mclk);
    primary_block_select_n <= 1'b1;
    alternate_block_select_n <= 1'b1;
    drv <= 1'b0;
  endtask : acc
endmodule : apd_host

// file: verif/tb_top.sv
// Decode bench
`timescale 1ns/1ps
module tb_top;
  logic        mclk, rst_n, pin_n, nv_pd_r, nv_init_r, nv_wr, nv_pd_o, nv_i_o;
  logic        cs1_n, cs3_n, rd_n, wr_n, u_oe_n, l_oe_n, reg_wr, reg_rd;
  logic [2:0]  rsel;
  logic [7:0]  u_in, l_in, u_out, l_out, reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, v;
  logic [15:0] q;
  logic [7:0]  dc [10] = '{8'hCA, 8'hCB, 8'h35, 8'hC5, 8'h39, 8'h30, 8'h31,
                           8'h3C, 8'hC0, 8'h50};
  int          failures, checks_done, cyc;
  apd_port #(.INIT_CYCLES(20)) i_apd_port (.mclk, .rst_n,
    .ce(1'b1), .primary_block_select_n(cs1_n),
    .alternate_block_select_n(cs3_n), .io_read_strobe_n(rd_n),
    .io_write_strobe_n(wr_n), .register_select_bits(rsel),
    .upper_data_byte_in(u_in), .lower_data_byte_in(l_in),
    .upper_data_byte_out(u_out), .lower_data_byte_out(l_out),
    .upper_data_byte_oe_n(u_oe_n), .lower_data_byte_oe_n(l_oe_n),
    .protect_powerdown_pin_n(pin_n), .diag_serial_clock(1'b0),
    .diag_serial_in(1'b0), .diag_serial_out(), .nv_pd_mode(nv_pd_r),
    .nv_init_done(nv_init_r), .nv_wr, .nv_pd_mode_out(nv_pd_o),
    .nv_init_done_out(nv_i_o), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  apd_host i_apd_host (.mclk, .primary_block_select_n(cs1_n),
    .alternate_block_select_n(cs3_n), .io_read_strobe_n(rd_n),
    .io_write_strobe_n(wr_n), .register_select_bits(rsel),
    .upper_data_byte_in(u_in), .lower_data_byte_in(l_in),
    .upper_data_byte_out(u_out), .lower_data_byte_out(l_out),
    .upper_data_byte_oe_n(u_oe_n), .lower_data_byte_oe_n(l_oe_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : rw
  task automatic rr(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    v = reg_rdata;
  endtask : rr
  task automatic hw(input logic alt, input logic [2:0] a, input logic [7:0] d);
    i_apd_host.acc(alt, 1'b1, a, {8'h00, d}, q);
  endtask : hw
  task automatic tfr(input logic [2:0] a, input logic [7:0] e);
    i_apd_host.acc(1'b0, 1'b0, a, 16'h0000, q);
    chk({24'h0, q[7:0]}, {24'h0, e});
  endtask : tfr
  task automatic st(input logic [2:0] e);
    rr(apd_pkg::RB_CTRL);
    chk({29'h0, v[7:5]}, {29'h0, e});
  endtask : st
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // NV store
  always @(posedge mclk) begin
    if (nv_wr) begin
      nv_pd_r <= nv_pd_o;
      nv_init_r <= nv_i_o;
    end
    cyc++;
    if (cyc == 8000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    {rst_n, nv_pd_r, nv_init_r, reg_wr, reg_rd} = 5'h00;
    {pin_n, reg_addr, reg_wdata, seed} = {1'b1, 40'h0, 32'hE807};
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    tfr(3'h7, apd_pkg::ST_BUSY);
    for (int i = 0; i < 200 && nv_init_r !== 1'b1; i++) @(posedge mclk);
    chk({31'h0, nv_init_r}, 32'h1);
    tfr(3'h7, apd_pkg::ST_READY);
    $display("done init");
    rr(apd_pkg::RB_GEOM);
    chk(v, {16'h375D, 8'h10, 8'h3F});
    rr(apd_pkg::RB_MAXLBA);
    chk(v, 32'h00D9FE30);
    rr(8'hFC);
    chk(v, 32'h0);
    rr(apd_pkg::RB_ZCFG);
    chk(v, 32'h0);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      rw(8'(apd_pkg::RB_ZONE + 4 * i), seed);
      rr(8'(apd_pkg::RB_ZONE + 4 * i));
      chk(v, {4'h0, seed[27:0]});
    end
    rw(apd_pkg::RB_DATA, seed);
    i_apd_host.acc(1'b0, 1'b0, 3'h0, 16'h0000, q);
    chk({16'h0, q}, {16'h0, seed[15:0]});
    hw(1'b0, 3'h1, 8'h01);
    hw(1'b0, 3'h7, 8'hEF);
    tfr(3'h0, seed[7:0]);
    $display("done registers");
    pin_n <= 1'b0;
    foreach (dc[i]) begin
      hw(1'b0, 3'h7, dc[i]);
      tfr(3'h7, 8'h51);
      tfr(3'h1, 8'h04);
      st(3'h2);
    end
    hw(1'b0, 3'h7, 8'hEC);
    st(3'h3);
    rw(apd_pkg::RB_CTRL, 32'h1);
    pin_n <= 1'b1;
    $display("done protect");
    hw(1'b0, 3'h1, 8'h01);
    hw(1'b0, 3'h7, 8'h8B);
    rw(apd_pkg::RB_CTRL, 32'h1);
    chk({31'h0, nv_pd_r}, 32'h1);
    hw(1'b0, 3'h7, 8'hEC);
    pin_n <= 1'b0;
    repeat (2) @(posedge mclk);
    st(3'h4);
    hw(1'b0, 3'h7, 8'hEC);
    st(3'h4);
    pin_n <= 1'b1;
    hw(1'b1, 3'h6, 8'h04);
    hw(1'b1, 3'h6, 8'h00);
    st(3'h2);
    chk({31'h0, v[4]}, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    st(3'h2);
    chk({31'h0, v[3]}, 32'h1);
    $display("done powerdown");
    end_of_test();
  end
endmodule : tb_top
